/* File: hdl/aprc_pkg.sv */
package aprc_pkg;

  // ==========================================================================
  // Widths and timing.
  // ==========================================================================
  localparam int unsigned RES_W        = 12;
  localparam int unsigned BUS_W        = 12;
  localparam int unsigned BYTE_W       = 8;
  localparam int unsigned HI_NIB_LSB   = 8;
  localparam int unsigned NIB_W        = 4;
  localparam int unsigned CLK_MHZ      = 250;
  localparam int unsigned CONV_TIME_NS = 6000;
  localparam int unsigned CONV_CYCLES  = (CONV_TIME_NS * CLK_MHZ) / 1000;
  localparam logic [RES_W-1:0] RESULT_RST = 12'h000;

  // Host command kinds.
  localparam logic [1:0] CMD_WORD  = 2'h0;
  localparam logic [1:0] CMD_LOW   = 2'h1;
  localparam logic [1:0] CMD_HIGH  = 2'h2;

  // ==========================================================================
  // Device conversion states.
  // ==========================================================================
  typedef enum logic [1:0] {
    APRC_IDLE = 2'b01,
    APRC_CONV = 2'b10
  } aprc_dev_state_type;

  // Host access states.
  typedef enum logic [3:0] {
    APRC_H_IDLE = 4'b0001,
    APRC_H_STRB = 4'b0010,
    APRC_H_WAIT = 4'b0100,
    APRC_H_DONE = 4'b1000
  } aprc_host_state_type;

endpackage : aprc_pkg

/* File: hdl/aprc_if.sv */
`timescale 1ns/100ps
`default_nettype none
// Parallel bus between the converter and its host.
interface aprc_if;
  import aprc_pkg::*;
  logic             cs_n;
  logic             rd_n;
  logic             high_byte_sel;
  logic             busy_n;
  logic [BUS_W-1:0] data_o;
  logic             data_oe;
  logic [BUS_W-1:0] data;

  // Resolved bus level seen by the host; undriven lines read low.
  assign data = data_oe ? data_o : 12'h000;

  modport dev (input cs_n, rd_n, high_byte_sel, output busy_n, data_o, data_oe);
  modport host (output cs_n, rd_n, high_byte_sel, input busy_n, data);
endinterface : aprc_if
`default_nettype wire

/* File: hdl/aprc_dev.sv */
`timescale 1ns/100ps
`default_nettype none
module aprc_dev #(
  parameter int unsigned CONV_CYC = aprc_pkg::CONV_CYCLES
) (
  input  wire logic                     clk_i,
  input  wire logic                     rst_n_i,
  aprc_if.dev                           bus,
  input  wire logic [aprc_pkg::RES_W-1:0] sample_i,
  output logic                          conv_done_o
);
  import aprc_pkg::*;

  // ==========================================================================
  // Parameter checks.
  // ==========================================================================
  // The conversion down-counter is sixteen bits wide and loads one less than
  // the conversion length, so lengths it cannot hold are refused when the
  // design is built rather than misbehaving in the field.
  if (CONV_CYC < 2 || CONV_CYC > 65535) begin : g_bad_conv_cyc
    $error("aprc_dev: CONV_CYC out of range");
  end

  // ==========================================================================
  // Pin synchronisers.
  // ==========================================================================
  logic [2:0] sync1_ff;
  logic [2:0] sync2_ff;
  logic [2:0] nxt_sync1;
  logic [2:0] nxt_sync2;
  logic       cs_n_s;
  logic       rd_n_s;
  logic       hbs_s;

  // Two flops on each control pin from the host, which drives it from its
  // own timing. They reset to all ones, which holds the start gate below
  // closed until the host's real levels have passed both flops. Only the
  // second flop is read by the logic that follows.
  always_comb begin
    nxt_sync1 = {bus.cs_n, bus.rd_n, bus.high_byte_sel};
    nxt_sync2 = sync1_ff;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sync1_ff <= 3'h7;
      sync2_ff <= 3'h7;
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
    end
  end

  assign cs_n_s = sync2_ff[2];
  assign rd_n_s = sync2_ff[1];
  assign hbs_s  = sync2_ff[0];

  // ==========================================================================
  // Conversion engine.
  // ==========================================================================
  aprc_dev_state_type state_ff;
  aprc_dev_state_type nxt_state;
  logic [15:0]        cnt_ff;
  logic [15:0]        nxt_cnt;
  logic [RES_W-1:0]   result_ff;
  logic [RES_W-1:0]   nxt_result;
  logic               start_req;
  logic               gate_s;
  logic               gate_ff;
  logic               nxt_gate;
  logic               done_ff;
  logic               nxt_done;

  // The three controls are gated together; all of them low opens the gate.
  assign gate_s = !cs_n_s && !rd_n_s && !hbs_s;

  // A conversion starts on the edge at which the gate opens, not on its
  // level. A slow read keeps its strobe low after busy rises, and a level
  // start would launch a second conversion at that moment. The gate flop
  // resets closed, like idle pins, so leaving reset makes no false edge.
  assign start_req = gate_s && !gate_ff;

  // Idle waits for a start and on it loads one less than the
  // conversion length; the conversion state counts down to zero, so busy stays low for exactly
  // the conversion length in cycles, then latches the sample. The output latch updates at
  // the same edge that ends the conversion, so busy and the new data change
  // together.
  always_comb begin
    nxt_state  = state_ff;
    nxt_cnt    = cnt_ff;
    nxt_result = result_ff;
    nxt_gate   = gate_s;
    nxt_done   = 1'b0;
    case (state_ff)
      APRC_IDLE: begin
        if (start_req) begin
          nxt_state = APRC_CONV;
          nxt_cnt   = 16'(CONV_CYC - 1);
        end
      end
      APRC_CONV: begin
        // Further start conditions are ignored in this state.
        if (cnt_ff == 16'h0000) begin
          nxt_state  = APRC_IDLE;
          nxt_result = sample_i;
          nxt_done   = 1'b1;
        end else begin
          nxt_cnt = cnt_ff - 16'h0001;
        end
      end
      default: begin
        nxt_state = APRC_IDLE;
      end
    endcase
  end

  // Registers the engine; the gate flop keeps the previous gate level so
  // that only its opening edge counts as a start.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_ff  <= APRC_IDLE;
      cnt_ff    <= 16'h0000;
      result_ff <= RESULT_RST;
      gate_ff   <= 1'b0;
      done_ff   <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      cnt_ff    <= nxt_cnt;
      result_ff <= nxt_result;
      gate_ff   <= nxt_gate;
      done_ff   <= nxt_done;
    end
  end

  // ==========================================================================
  // Output drivers.
  // ==========================================================================
  logic [BUS_W-1:0] dout_ff;
  logic [BUS_W-1:0] nxt_dout;
  logic             oe_ff;
  logic             nxt_oe;

  // Builds the bus word: the top nibble always carries result bits 11..8,
  // and the low byte carries bits 7..0, or zeros over bits 11..8 while the
  // high byte is selected.
  function automatic logic [BUS_W-1:0] aprc_bus_word(input logic [RES_W-1:0] res,
                                                     input logic             hi_sel);
    logic [BUS_W-1:0] word;
    word[BUS_W-1:HI_NIB_LSB] = res[RES_W-1:HI_NIB_LSB];
    if (hi_sel) begin
      word[BYTE_W-1:0] = {4'h0, res[RES_W-1:HI_NIB_LSB]};
    end else begin
      word[BYTE_W-1:0] = res[BYTE_W-1:0];
    end
    return word;
  endfunction : aprc_bus_word

  // Output enable follows select and strobe. The bus word is built from the
  // next result, so new data lands on the same edge as busy rising; old data
  // is shown until then. A byte select that changes in the middle of an
  // access is not supported: the low byte follows the synchronised select.
  always_comb begin
    nxt_oe   = !cs_n_s && !rd_n_s;
    nxt_dout = aprc_bus_word(nxt_result, hbs_s);
  end

  // The data lines and their enable come from flops, so the bus shows no
  // decode glitches while the host samples it.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      dout_ff <= 12'h000;
      oe_ff   <= 1'b0;
    end else begin
      dout_ff <= nxt_dout;
      oe_ff   <= nxt_oe;
    end
  end

  // Registered data and enable go straight to the bus.
  assign bus.data_o  = dout_ff;
  assign bus.data_oe = oe_ff;

  // ==========================================================================
  // Status outputs.
  // ==========================================================================
  // Busy is decoded from the state register alone, so it is glitch free. It
  // is low for the whole conversion and rises on the edge that latches the
  // result, which is what lets a slow host hold its cycle open on it.
  assign bus.busy_n  = (state_ff != APRC_CONV);
  // One-cycle pulse the cycle after a result is latched, for local logic.
  assign conv_done_o = done_ff;

endmodule : aprc_dev
`default_nettype wire

/* File: hdl/aprc_host.sv */
`timescale 1ns/100ps
`default_nettype none
// Host end: performs word, low-byte or high-byte reads on the bus.
module aprc_host (
  input  wire logic                       clk_i,
  input  wire logic                       rst_n_i,
  aprc_if.host                            bus,
  input  wire logic                       req_valid_i,
  input  wire logic [1:0]                 req_cmd_i,
  input  wire logic                       req_slow_i,
  output logic                            req_ready_o,
  output logic                            rsp_valid_o,
  output logic [aprc_pkg::BUS_W-1:0]      rsp_data_o
);
  import aprc_pkg::*;

  // ==========================================================================
  // Input synchronisers.
  // ==========================================================================
  logic             busy1_ff;
  logic             busy2_ff;
  logic [BUS_W-1:0] dat1_ff;
  logic [BUS_W-1:0] dat2_ff;
  logic             nxt_busy1;
  logic             nxt_busy2;
  logic [BUS_W-1:0] nxt_dat1;
  logic [BUS_W-1:0] nxt_dat2;

  // Two flops on busy and on the data lines; only the second is read.
  always_comb begin
    nxt_busy1 = bus.busy_n;
    nxt_busy2 = busy1_ff;
    nxt_dat1  = bus.data;
    nxt_dat2  = dat1_ff;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      busy1_ff <= 1'b1;
      busy2_ff <= 1'b1;
      dat1_ff  <= 12'h000;
      dat2_ff  <= 12'h000;
    end else begin
      busy1_ff <= nxt_busy1;
      busy2_ff <= nxt_busy2;
      dat1_ff  <= nxt_dat1;
      dat2_ff  <= nxt_dat2;
    end
  end

  // ==========================================================================
  // Access sequencer.
  // ==========================================================================
  aprc_host_state_type state_ff;
  aprc_host_state_type nxt_state;
  logic [3:0]          cnt_ff;
  logic [3:0]          nxt_cnt;
  logic                slow_ff;
  logic                nxt_slow;
  logic                hbs_ff;
  logic                nxt_hbs;
  logic [BUS_W-1:0]    rsp_ff;
  logic [BUS_W-1:0]    nxt_rsp;
  logic                rv_ff;
  logic                nxt_rv;

  // Strobe for a fixed settle time, then in slow mode hold the cycle open
  // (acknowledge withheld) while busy is low.
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_slow  = slow_ff;
    nxt_hbs   = hbs_ff;
    nxt_rsp   = rsp_ff;
    nxt_rv    = 1'b0;
    case (state_ff)
      APRC_H_IDLE: begin
        if (req_valid_i) begin
          nxt_state = APRC_H_STRB;
          nxt_cnt   = 4'h6;
          // High byte is an odd address; no wait is expected for it.
          nxt_hbs   = (req_cmd_i == CMD_HIGH);
          nxt_slow  = req_slow_i && (req_cmd_i != CMD_HIGH);
        end
      end
      APRC_H_STRB: begin
        if (cnt_ff == 4'h0) begin
          nxt_state = slow_ff ? APRC_H_WAIT : APRC_H_DONE;
        end else begin
          nxt_cnt = cnt_ff - 4'h1;
        end
      end
      APRC_H_WAIT: begin
        if (busy2_ff) begin
          nxt_state = APRC_H_DONE;
          nxt_cnt   = 4'h3;
        end
      end
      APRC_H_DONE: begin
        if (cnt_ff == 4'h0) begin
          nxt_state = APRC_H_IDLE;
          nxt_rsp   = dat2_ff;
          nxt_rv    = 1'b1;
        end else begin
          nxt_cnt = cnt_ff - 4'h1;
        end
      end
      default: begin
        nxt_state = APRC_H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_ff <= APRC_H_IDLE;
      cnt_ff   <= 4'h0;
      slow_ff  <= 1'b0;
      hbs_ff   <= 1'b0;
      rsp_ff   <= 12'h000;
      rv_ff    <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      slow_ff  <= nxt_slow;
      hbs_ff   <= nxt_hbs;
      rsp_ff   <= nxt_rsp;
      rv_ff    <= nxt_rv;
    end
  end

  // Spacing of ROM reads by the conversion time is left to the requester.
  assign bus.cs_n          = (state_ff == APRC_H_IDLE);
  assign bus.rd_n          = (state_ff == APRC_H_IDLE);
  assign bus.high_byte_sel = hbs_ff;
  assign req_ready_o       = (state_ff == APRC_H_IDLE);
  assign rsp_valid_o       = rv_ff;
  assign rsp_data_o        = rsp_ff;

endmodule : aprc_host
`default_nettype wire

/* File: verif/aprc_checker.sv */
`timescale 1ns/100ps
`default_nettype none
// ======
// Bus checker.
module aprc_checker #(
  parameter int unsigned CONV_CYC = aprc_pkg::CONV_CYCLES
) (
  input wire logic                      clk_i,
  input wire logic                      rst_n_i,
  input wire logic                      cs_n,
  input wire logic                      rd_n,
  input wire logic                      high_byte_sel,
  input wire logic                      busy_n,
  input wire logic [aprc_pkg::BUS_W-1:0] data_o,
  input wire logic                      data_oe
);
  import aprc_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [15:0] low_cnt_ff;
  logic [15:0] nxt_low_cnt;

  // Counts how long busy has been low.
  always_comb begin
    nxt_low_cnt = busy_n ? 16'h0000 : low_cnt_ff + 16'h0001;
  end
  always_ff @(posedge clk_i) begin
    low_cnt_ff <= rst_n_i ? nxt_low_cnt : 16'h0000;
  end

  // A start is strobe and select low with the high byte off, on an idle device.
  sequence s_start;
    $fell(cs_n) && !rd_n && !high_byte_sel && busy_n;
  endsequence
  sequence s_busy_fall;
    ##2 busy_n ##1 !busy_n;
  endsequence

  a_start_cause: assert property ($fell(busy_n)
    |-> $past(!cs_n && !rd_n && !high_byte_sel, 3))
    else $error("busy fell without a start");
  a_start_delay: assert property (s_start |-> s_busy_fall)
    else $error("start not followed by busy");
  a_busy_span: assert property ($rose(busy_n)
    |-> low_cnt_ff == 16'(CONV_CYC))
    else $error("busy low for wrong length");
  a_oe_follow: assert property (data_oe == $past(!cs_n && !rd_n, 3))
    else $error("output enable does not follow strobe");
  a_oe_release: assert property ($rose(cs_n) |-> data_oe [*3] ##1 !data_oe)
    else $error("output enable not released");
  a_hi_format: assert property (data_oe && $past(high_byte_sel, 3)
    && $past(high_byte_sel, 4) |-> data_o[7:4] == 4'h0 && data_o[3:0] == data_o[11:8])
    else $error("high byte format wrong");
  a_conv_hold: assert property (!busy_n && $past(!busy_n) |-> $stable(data_o))
    else $error("data moved during conversion");
  a_hi_no_start: assert property (busy_n && high_byte_sel && $fell(cs_n)
    |-> busy_n [*5])
    else $error("high byte read started a conversion");
endmodule : aprc_checker
`default_nettype wire

/* File: verif/tb.sv */
`timescale 1ns/100ps
`default_nettype none
// ======
// Testbench.
module tb;
  import aprc_pkg::*;
  localparam int unsigned CONV = 40;
  logic             clk_i, rst_n_i, req_valid_i, req_slow_i, req_ready_o, rsp_valid_o;
  logic             conv_done_o;
  logic [1:0]       req_cmd_i;
  logic [BUS_W-1:0] rsp_data_o;
  logic [RES_W-1:0] sample_i;
  int               miscompares, cmp_count, cyc;
  int               done_count;

  aprc_if bus ();
  aprc_dev #(.CONV_CYC(CONV)) u_aprc_dev (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus(bus),
    .sample_i(sample_i), .conv_done_o(conv_done_o));
  aprc_host u_aprc_host (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus(bus),
    .req_valid_i(req_valid_i), .req_cmd_i(req_cmd_i), .req_slow_i(req_slow_i),
    .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o));
  aprc_checker #(.CONV_CYC(CONV)) u_aprc_checker (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .cs_n(bus.cs_n), .rd_n(bus.rd_n), .high_byte_sel(bus.high_byte_sel), .busy_n(bus.busy_n),
    .data_o(bus.data_o), .data_oe(bus.data_oe));

  // Prints the verdict and ends the run.
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop

  // Compares a seen value with the expected one.
  task automatic check(input logic [BUS_W-1:0] seen, input logic [BUS_W-1:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %0t saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One host access; cyc counts the cycles until the response.
  task automatic rd(input logic [1:0] cmd, input logic slow, input logic [BUS_W-1:0] exp);
    check(BUS_W'(req_ready_o), 12'h001);
    cyc = 0;
    req_cmd_i = cmd;
    req_slow_i = slow;
    req_valid_i = 1'b1;
    @(posedge clk_i);
    #1 req_valid_i = 1'b0;
    while (rsp_valid_o !== 1'b1) begin
      @(posedge clk_i);
      #1 cyc++;
      if (cyc > 300) begin
        miscompares++;
        report_and_stop();
      end
    end
    check(rsp_data_o, exp);
  endtask : rd

  // Leaves room for a conversion to finish between reads.
  task automatic gap();
    repeat (CONV + 8) @(posedge clk_i);
    #1;
  endtask : gap

  // Free-running clock.
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // Counts finished conversions at mid-cycle, where the done pulse stands.
  always @(negedge clk_i) begin
    if (conv_done_o === 1'b1) done_count++;
  end

  // Main sequence.
  initial begin
    rst_n_i = 1'b0;
    req_valid_i = 1'b0;
    req_cmd_i = CMD_WORD;
    req_slow_i = 1'b0;
    sample_i = 12'h93c;
    repeat (16) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    rd(CMD_WORD, 1'b1, 12'h93c);
    check(BUS_W'(cyc > CONV), 12'h001);
    sample_i = 12'h5a7;
    rd(CMD_LOW, 1'b1, 12'h5a7);
    check(BUS_W'(cyc > CONV), 12'h001);
    rd(CMD_HIGH, 1'b1, 12'h505);
    check(BUS_W'(cyc < 16), 12'h001);
    $display("slow tests done");
    sample_i = 12'hc31;
    rd(CMD_WORD, 1'b0, 12'h5a7);
    check(BUS_W'(cyc < 16), 12'h001);
    gap();
    sample_i = 12'h2e8;
    rd(CMD_WORD, 1'b0, 12'hc31);
    gap();
    sample_i = 12'h7f4;
    rd(CMD_LOW, 1'b0, 12'h2e8);
    gap();
    rd(CMD_HIGH, 1'b0, 12'h707);
    sample_i = 12'h1b6;
    rd(CMD_LOW, 1'b0, 12'h7f4);
    gap();
    $display("rom tests done");
    sample_i = 12'h6d9;
    rd(CMD_WORD, 1'b0, 12'h1b6);
    rd(CMD_WORD, 1'b0, 12'h1b6);
    gap();
    rd(CMD_WORD, 1'b0, 12'h6d9);
    gap();
    check(BUS_W'(done_count), 12'h008);
    $display("restart test done");
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
